// file: pkg/cyt_params.svh
// Timing figures, opcodes and address constants for the instruction cycle sequencer
`ifndef CYT_PARAMS_SVH
`define CYT_PARAMS_SVH

// Program byte counts
`define CYT_BYTES_1 2'h1
`define CYT_BYTES_2 2'h2
`define CYT_BYTES_3 2'h3

// Execution lengths in system clock cycles
`define CYT_CYC_1 4'h1
`define CYT_CYC_2 4'h2
`define CYT_CYC_3 4'h3
`define CYT_CYC_MUL 4'h4
`define CYT_CYC_DIV 4'h8

// Lowest direct address that lands in the special function registers
`define CYT_SFR_BASE 8'h80

// Opcodes that are checked by name
`define CYT_OP_MUL 8'hA4
`define CYT_OP_DIV 8'h84
`define CYT_OP_JC 8'h40
`define CYT_OP_PUSH 8'hC0
`define CYT_OP_POP 8'hD0
`define CYT_OP_CODE_PC 8'h83
`define CYT_OP_CODE_DP 8'h93
`define CYT_OP_XRD_DP 8'hE0
`define CYT_OP_XWR_DP 8'hF0
`define CYT_OP_MOV_DD 8'h85

`endif

// file: pkg/cyt_pkg.sv
// Types shared by the instruction cycle sequencer and its operand mapper
package cyt_pkg;

    // Operand addressing class of an instruction
    typedef enum logic [1:0] {
        MD_NONE = 2'h0,
        MD_BANK = 2'h1,
        MD_IND = 2'h2,
        MD_DIR = 2'h3
    } cyt_mode_type;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXEC = 3'b100
    } cyt_state_type;

    // Decoded cost of one instruction
    typedef struct packed {
        logic known;
        logic cond;
        logic [1:0] bytes;
        logic [3:0] cycles;
        cyt_mode_type mode;
    } cyt_dec_type;

    // Resolved data location of the operand
    typedef struct packed {
        logic valid;
        logic is_sfr;
        logic [7:0] addr;
    } cyt_oper_type;

endpackage

// file: src/cyt_operand_map.sv
// Maps an instruction operand to its internal data location
`timescale 1ns/10ps
`default_nettype none
`include "cyt_params.svh"

module cyt_operand_map
    import cyt_pkg::*;
(
    // Instruction being completed
    input wire logic [7:0] opcode,
    input wire cyt_mode_type mode,
    input wire logic [7:0] operand,
    // Active register bank
    input wire logic [1:0] bank_sel,
    // Resolved location
    output var cyt_oper_type oper
);

    // ****************************************
    // Address forming
    // ****************************************
    wire logic [7:0] bank_addr;
    wire logic [7:0] ptr_addr;

    assign bank_addr = {3'h0, bank_sel, opcode[2:0]};
    assign ptr_addr = {3'h0, bank_sel, 2'h0, opcode[0]};

    // Direct addresses split RAM and SFR space on the top half
    assign oper.valid = (mode != MD_NONE);
    assign oper.is_sfr = (mode == MD_DIR) && (operand >= `CYT_SFR_BASE);
    assign oper.addr = (mode == MD_BANK) ? bank_addr :
                       (mode == MD_IND) ? ptr_addr :
                       (mode == MD_DIR) ? operand : 8'h00;

endmodule // cyt_operand_map
`default_nettype wire

// file: src/cyt_sequencer.sv
// Instruction decode and clock-cycle sequencer for the pipelined 8-bit core
//
// Behaviour
// - Execution is counted in single clock cycles, never in grouped machine cycles.
// - Most instructions take as many cycles as they have program bytes.
// - A conditional branch not taken ends one cycle earlier than when taken.
// - Two-operand arithmetic: bank register 1/1, direct or immediate 2/2.
// - Indirect arithmetic 1 byte 2 cycles; increment/decrement alike; pointer increment 1 cycle.
// - Multiply 4 cycles, divide 8 cycles, decimal adjust 1 cycle, one byte each.
// - Logic into accumulator: bank 1 cycle, others 2; result to direct 2/2.
// - Logic of immediate into direct byte takes three bytes, three cycles.
// - Accumulator-only operations take one byte and one cycle.
// - Moves: bank 1 cycle, direct/immediate 2/2, indirect 2, direct destination 3/3.
// - Loading the 16-bit data pointer takes three bytes, three cycles.
// - Code byte read into accumulator takes one byte, three cycles.
// - External data reads and writes take one byte, three cycles, either address width.
// - Stack push and pop of a direct byte take two bytes, two cycles.
// - Exchange with bank register 1 cycle; direct, indirect and nibble exchange 2.
// - Carry clear/set/complement 1 cycle; direct bit operations 2 bytes, 2 cycles.
// - Bank operand selects one of eight registers in the active bank.
// - Indirect operand address comes from the first two bank registers only.
// - Direct address lower half is data RAM, upper half special registers.
`timescale 1ns/10ps
`default_nettype none
`include "cyt_params.svh"

module cyt_sequencer
    import cyt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program byte stream
    input wire logic [7:0] code_byte,
    input wire logic code_valid,
    output logic fetch_req,
    // Execution context
    input wire logic branch_taken,
    input wire logic [1:0] bank_sel,
    // Instruction status
    output logic instr_start,
    output logic instr_done,
    output logic [7:0] opcode,
    output logic [7:0] operand_byte,
    output logic [1:0] instr_bytes,
    output logic [3:0] instr_cycles,
    output logic branch_went,
    output logic op_known,
    output var cyt_oper_type oper
);

    // ****************************************
    // Short names for the timing figures
    // ****************************************
    localparam logic [1:0] B1 = `CYT_BYTES_1;
    localparam logic [1:0] B2 = `CYT_BYTES_2;
    localparam logic [1:0] B3 = `CYT_BYTES_3;
    localparam logic [3:0] C1 = `CYT_CYC_1;
    localparam logic [3:0] C2 = `CYT_CYC_2;
    localparam logic [3:0] C3 = `CYT_CYC_3;
    localparam cyt_dec_type DEC_IDLE = '{known: 1'b1, cond: 1'b0, bytes: `CYT_BYTES_1,
                                         cycles: `CYT_CYC_1, mode: MD_NONE};

    // ****************************************
    // Decode table
    // ****************************************

    // Build one table entry
    function automatic cyt_dec_type mk(input logic [1:0] b, input logic [3:0] c,
                                       input cyt_mode_type m, input logic j);
        mk = '{known: 1'b1, cond: j, bytes: b, cycles: c, mode: m};
    endfunction

    function automatic cyt_dec_type src(input logic [3:0] lo);
        if (lo[3]) begin
            src = mk(B1, C1, MD_BANK, 1'b0);
        end else if (lo[3:1] == 3'h3) begin
            src = mk(B1, C2, MD_IND, 1'b0);
        end else if (lo == 4'h5) begin
            src = mk(B2, C2, MD_DIR, 1'b0);
        end else begin
            src = mk(B2, C2, MD_NONE, 1'b0);
        end
    endfunction

    // Cost of any opcode; branches and calls outside this block are flagged unknown
    function automatic cyt_dec_type decode(input logic [7:0] op);
        logic [3:0] lo;
        logic ind;
        cyt_dec_type d;
        lo = op[3:0];
        ind = (lo[3:1] == 3'h3);
        d = mk(B1, C1, MD_NONE, 1'b0);
        case (op[7:4])
            4'h0, 4'h1: begin
                if (lo >= 4'h5) d = src(lo);
                else if (op == 8'h10) d = mk(B3, C3, MD_NONE, 1'b1);
                else if (lo == 4'h1 || lo == 4'h2) d.known = 1'b0;
            end
            // Add, add with carry, left rotates
            4'h2, 4'h3: begin
                if (lo >= 4'h4) d = src(lo);
                else if (lo == 4'h0) d = mk(B3, C3, MD_NONE, 1'b1);
                else if (lo != 4'h3) d.known = 1'b0;
            end
            4'h4, 4'h5, 4'h6: begin
                if (lo >= 4'h4) d = src(lo);
                else if (lo == 4'h0) d = mk(B2, C2, MD_NONE, 1'b1);
                else if (lo == 4'h2) d = mk(B2, C2, MD_DIR, 1'b0);
                else if (lo == 4'h3) d = mk(B3, C3, MD_DIR, 1'b0);
                else d.known = 1'b0;
            end
            4'h7: begin
                if (lo[3]) d = mk(B2, C2, MD_BANK, 1'b0);
                else if (ind) d = mk(B2, C2, MD_IND, 1'b0);
                else if (lo == 4'h5) d = mk(B3, C3, MD_DIR, 1'b0);
                else if (lo == 4'h0) d = mk(B2, C2, MD_NONE, 1'b1);
                else if (lo == 4'h2 || lo == 4'h4) d = mk(B2, C2, MD_NONE, 1'b0);
                else d.known = 1'b0;
            end
            4'h8: begin
                if (lo[3]) d = mk(B2, C2, MD_BANK, 1'b0);
                else if (ind) d = mk(B2, C2, MD_IND, 1'b0);
                else if (lo == 4'h5) d = mk(B3, C3, MD_DIR, 1'b0);
                else if (lo == 4'h4) d = mk(B1, `CYT_CYC_DIV, MD_NONE, 1'b0);
                else if (lo == 4'h3) d = mk(B1, C3, MD_NONE, 1'b0);
                else if (lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else d.known = 1'b0;
            end
            4'h9: begin
                if (lo >= 4'h4) d = src(lo);
                else if (lo == 4'h0) d = mk(B3, C3, MD_NONE, 1'b0);
                else if (lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else if (lo == 4'h3) d = mk(B1, C3, MD_NONE, 1'b0);
                else d.known = 1'b0;
            end
            // Moves from direct, multiply, pointer increment
            4'hA: begin
                if (lo[3]) d = mk(B2, C2, MD_BANK, 1'b0);
                else if (ind) d = mk(B2, C2, MD_IND, 1'b0);
                else if (lo == 4'h4) d = mk(B1, `CYT_CYC_MUL, MD_NONE, 1'b0);
                else if (lo == 4'h0 || lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else if (lo == 4'h1) d.known = 1'b0;
            end
            // Compare-and-jump family
            4'hB: begin
                if (lo[3]) d = mk(B3, C3, MD_BANK, 1'b1);
                else if (ind) d = mk(B3, `CYT_CYC_MUL, MD_IND, 1'b1);
                else if (lo == 4'h5) d = mk(B3, `CYT_CYC_MUL, MD_DIR, 1'b1);
                else if (lo == 4'h4) d = mk(B3, C3, MD_NONE, 1'b1);
                else if (lo == 4'h0 || lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else if (lo == 4'h1) d.known = 1'b0;
            end
            4'hC: begin
                if (lo >= 4'h5) d = src(lo);
                else if (lo == 4'h0) d = mk(B2, C2, MD_DIR, 1'b0);
                else if (lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else if (lo == 4'h1) d.known = 1'b0;
            end
            4'hD: begin
                if (lo[3]) d = mk(B2, C2, MD_BANK, 1'b1);
                else if (ind) d = mk(B1, C2, MD_IND, 1'b0);
                else if (lo == 4'h5) d = mk(B3, C3, MD_DIR, 1'b1);
                else if (lo == 4'h0) d = mk(B2, C2, MD_DIR, 1'b0);
                else if (lo == 4'h2) d = mk(B2, C2, MD_NONE, 1'b0);
                else if (lo == 4'h1) d.known = 1'b0;
            end
            // External data moves, accumulator clear and complement, moves
            default: begin
                if (lo >= 4'h5) d = src(lo);
                else if (lo == 4'h0) d = mk(B1, C3, MD_NONE, 1'b0);
                else if (lo == 4'h2 || lo == 4'h3) d = mk(B1, C3, MD_IND, 1'b0);
                else if (lo == 4'h1) d.known = 1'b0;
            end
        endcase
        decode = d;
    endfunction

    // ****************************************
    // Sequencer state
    // ****************************************
    cyt_state_type state;
    cyt_state_type next_state;
    cyt_dec_type dec;
    logic [3:0] cyc_n;
    logic [1:0] byte_n;

    wire cyt_dec_type dec_now;
    wire cyt_dec_type cur_dec;
    wire logic take_op;
    wire logic need_byte;
    wire logic advance;
    wire logic [3:0] cur_n;
    wire logic at_base;
    wire logic finish;
    wire logic [1:0] next_byte_n;
    wire logic [3:0] next_cyc_n;
    wire logic [7:0] next_opcode;
    wire logic [7:0] next_operand;
    wire logic next_fetch_req;
    wire cyt_oper_type next_oper;

    assign dec_now = decode(code_byte);
    // Opcode taken only while the memory offers a byte
    assign take_op = (state == ST_FETCH) && code_valid;
    // One program byte per cycle until all are in
    assign need_byte = (state == ST_EXEC) && (byte_n < dec.bytes);
    // A missing operand byte stalls; the cycle is not counted
    assign advance = (state == ST_EXEC) && (!need_byte || code_valid);
    assign cur_dec = take_op ? dec_now : dec;
    assign cur_n = take_op ? C1 : cyc_n;
    assign at_base = (cur_n == cur_dec.cycles);

    assign finish = (take_op || advance) &&
                    ((at_base && !(cur_dec.cond && branch_taken)) ||
                     (cur_n == 4'(cur_dec.cycles + C1)));

    assign next_cyc_n = take_op ? C2 : advance ? 4'(cyc_n + C1) : cyc_n;
    assign next_byte_n = take_op ? B1 : (advance && need_byte) ? 2'(byte_n + B1) : byte_n;
    assign next_opcode = take_op ? code_byte : opcode;
    // Second program byte is the operand that the mapper resolves
    assign next_operand = (advance && need_byte && byte_n == B1) ? code_byte : operand_byte;
    assign next_fetch_req = (next_state == ST_FETCH) ||
                            ((next_state == ST_EXEC) && (next_byte_n < cur_dec.bytes));

    // Next state
    always_comb begin
        case (state)
            ST_BOOT: next_state = ST_FETCH;
            ST_FETCH: next_state = (take_op && !finish) ? ST_EXEC : ST_FETCH;
            ST_EXEC: next_state = finish ? ST_FETCH : ST_EXEC;
            default: next_state = ST_BOOT;
        endcase
    end

    // Operand location, resolved ahead of the completion edge
    cyt_operand_map u_map (
        .opcode(next_opcode),
        .mode(cur_dec.mode),
        .operand(next_operand),
        .bank_sel(bank_sel),
        .oper(next_oper)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_BOOT;
            dec <= DEC_IDLE;
            cyc_n <= C1;
            byte_n <= B1;
        end else begin
            state <= next_state;
            dec <= cur_dec;
            cyc_n <= next_cyc_n;
            byte_n <= next_byte_n;
        end
    end

    // Status outputs, all registered so they stand for a whole cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_req <= 1'b0;
            instr_start <= 1'b0;
            instr_done <= 1'b0;
            opcode <= 8'h00;
            operand_byte <= 8'h00;
        end else begin
            fetch_req <= next_fetch_req;
            instr_start <= take_op;
            instr_done <= finish;
            opcode <= next_opcode;
            operand_byte <= next_operand;
        end
    end

    // Completion record, held until the next instruction ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_bytes <= 2'h0;
            instr_cycles <= 4'h0;
            branch_went <= 1'b0;
            op_known <= 1'b0;
            oper <= '0;
        end else if (finish) begin
            instr_bytes <= cur_dec.bytes;
            instr_cycles <= cur_n;
            branch_went <= !at_base;
            op_known <= cur_dec.known;
            oper <= next_oper;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_gap2;
        !instr_done [*2] ##1 instr_done;
    endsequence
    sequence s_gap3;
        !instr_done [*3] ##1 instr_done;
    endsequence
    sequence s_gap7;
        !instr_done [*7] ##1 instr_done;
    endsequence

    property p_count_clock;
        (state == ST_EXEC) && !fetch_req |=> (cyc_n == 4'($past(cyc_n) + C1));
    endproperty
    a_count_clock: assert property (p_count_clock) else $error("cycle count skipped");

    property p_direct_alu;
        instr_done && (opcode[3:0] == 4'h5) && (opcode[7:4] inside {4'h2, 4'h3, 4'h5, 4'h9})
            |-> (instr_bytes == B2) && (instr_cycles == C2);
    endproperty
    a_direct_alu: assert property (p_direct_alu) else $error("direct operand cost wrong");

    property p_jc_extend;
        instr_done && (opcode == `CYT_OP_JC) |-> instr_cycles == (branch_went ? C3 : C2);
    endproperty
    a_jc_extend: assert property (p_jc_extend) else $error("branch length wrong");

    property p_rn_alu;
        instr_done && opcode[3] && (opcode[7:4] inside {4'h2, 4'h3, 4'h9, 4'h5})
            |-> (instr_cycles == C1) && oper.valid && (oper.addr[7:5] == 3'h0);
    endproperty
    a_rn_alu: assert property (p_rn_alu) else $error("bank operand wrong");

    property p_ind_alu;
        instr_done && (opcode[3:1] == 3'h3) && (opcode[7:4] inside {4'h0, 4'h2, 4'h3, 4'h9})
            |-> (instr_bytes == B1) && (instr_cycles == C2) && (oper.addr[2:1] == 2'h0);
    endproperty
    a_ind_alu: assert property (p_ind_alu) else $error("indirect cost wrong");

    property p_mul;
        instr_start && (opcode == `CYT_OP_MUL) |-> s_gap3;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply length wrong");

    property p_div;
        instr_start && (opcode == `CYT_OP_DIV) |-> s_gap7;
    endproperty
    a_div: assert property (p_div) else $error("divide length wrong");

    property p_logic_imm_dir;
        instr_done && (opcode[3:0] == 4'h3) && (opcode[7:4] inside {4'h4, 4'h5, 4'h6})
            |-> (instr_bytes == B3) && (instr_cycles == C3);
    endproperty
    a_logic_imm_dir: assert property (p_logic_imm_dir) else $error("logic to direct wrong");

    property p_xdata;
        instr_start && (opcode inside {`CYT_OP_XRD_DP, `CYT_OP_XWR_DP, `CYT_OP_CODE_PC, `CYT_OP_CODE_DP})
            |-> s_gap2 ##0 (instr_cycles == C3);
    endproperty
    a_xdata: assert property (p_xdata) else $error("three-cycle move wrong");

    property p_stack;
        instr_done && (opcode inside {`CYT_OP_PUSH, `CYT_OP_POP})
            |-> (instr_bytes == B2) && (instr_cycles == C2);
    endproperty
    a_stack: assert property (p_stack) else $error("stack move wrong");

    property p_sfr_split;
        instr_done && (opcode == `CYT_OP_MOV_DD) |-> oper.is_sfr == operand_byte[7];
    endproperty
    a_sfr_split: assert property (p_sfr_split) else $error("direct space split wrong");

    property p_boot;
        (state == ST_BOOT) |=> fetch_req && (state == ST_FETCH);
    endproperty
    a_boot: assert property (p_boot) else $error("fetch not restarted");

endmodule // cyt_sequencer
`default_nettype wire

// file: tb/cyt_sequencer_tb_top.sv
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
`include "cyt_params.svh"

module cyt_sequencer_tb_top import cyt_pkg::*; ;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] code_byte = 8'h00;
    logic code_valid = 1'b0;
    logic branch_taken = 1'b0;
    logic [1:0] bank_sel = 2'h0;
    logic fetch_req, instr_start, instr_done, branch_went, op_known;
    logic [7:0] opcode, operand_byte;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles;
    cyt_oper_type oper;
    int err_total = 0;
    int comparisons = 0;
    int ticks = 0;

    cyt_sequencer u_cyt_sequencer (
        .clk(clk), .rst_n(rst_n), .code_byte(code_byte), .code_valid(code_valid),
        .fetch_req(fetch_req), .branch_taken(branch_taken), .bank_sel(bank_sel),
        .instr_start(instr_start), .instr_done(instr_done), .opcode(opcode),
        .operand_byte(operand_byte), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles),
        .branch_went(branch_went), .op_known(op_known), .oper(oper)
    );

    // 10 MHz clock
    initial forever #50 clk = ~clk;

    // Hang guard, far above the 150 or so cycles the run needs
    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            err_total++;
            stop_test();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Feeds one instruction; gap puts a stall before byte two
    task automatic run(input logic [7:0] op, b2, input int eb, ec, tk, gap, kn);
        int cnt;
        int w;
        logic hit;
        cnt = 0;
        branch_taken = tk[0];
        for (int i = 0; i < eb; i++) begin
            if (gap != 0 && i == 1) begin
                code_valid = 1'b0;
                @(negedge clk);
                cnt++;
            end
            code_byte = (i == 0) ? op : ((i == 1) ? b2 : 8'h3C);
            code_valid = 1'b1;
            w = 0;
            do begin
                hit = fetch_req;
                @(negedge clk);
                w++;
                if (i > 0 || hit) cnt++;
            end while (!hit && w < 20);
            // Start pulse stands in the cycle after the opcode edge
            if (i == 0) check("instr_start", instr_start, 1);
        end
        // Done pulse must land exactly after the documented count
        // Valid drops only while waiting, never in the step where the next call raises it
        while (instr_done !== 1'b1 && cnt < 20) begin
            code_valid = 1'b0;
            @(negedge clk);
            cnt++;
        end
        check("done_delay", cnt, ec + tk + gap);
        if (eb > 1) check("operand_byte", operand_byte, b2);
        check("instr_cycles", instr_cycles, ec + tk);
        check("instr_bytes", instr_bytes, eb);
        check("branch_went", branch_went, tk);
        check("opcode", opcode, op);
        check("op_known", op_known, kn);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_arith();
        run(8'h2B, 8'h00, 1, 1, 0, 0, 1);
        run(8'h35, 8'h20, 2, 2, 0, 0, 1);
        run(8'h94, 8'h11, 2, 2, 0, 0, 1);
        run(8'h27, 8'h00, 1, 2, 0, 0, 1);
        run(8'h05, 8'h30, 2, 2, 0, 0, 1);
        run(8'h16, 8'h00, 1, 2, 0, 0, 1);
        run(8'hA3, 8'h00, 1, 1, 0, 0, 1);
    endtask

    task automatic t_muldiv();
        run(`CYT_OP_MUL, 8'h00, 1, 4, 0, 0, 1);
        run(`CYT_OP_DIV, 8'h00, 1, 8, 0, 0, 1);
        run(8'hD4, 8'h00, 1, 1, 0, 0, 1);
    endtask

    task automatic t_logic();
        run(8'h58, 8'h00, 1, 1, 0, 0, 1);
        run(8'h66, 8'h00, 1, 2, 0, 0, 1);
        run(8'h44, 8'h0F, 2, 2, 0, 0, 1);
        run(8'h42, 8'h40, 2, 2, 0, 0, 1);
        run(8'h53, 8'h40, 3, 3, 0, 0, 1);
        run(8'h43, 8'h41, 3, 3, 0, 0, 1);
        run(8'h63, 8'h42, 3, 3, 0, 0, 1);
    endtask

    task automatic t_acc();
        logic [7:0] ops [7];
        ops = '{8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4};
        // Back-to-back one-cycle ops
        foreach (ops[k]) run(ops[k], 8'h00, 1, 1, 0, 0, 1);
    endtask

    task automatic t_move();
        run(8'hEA, 8'h00, 1, 1, 0, 0, 1);
        run(8'h74, 8'h55, 2, 2, 0, 0, 1);
        run(8'hE7, 8'h00, 1, 2, 0, 0, 1);
        run(8'hF6, 8'h00, 1, 2, 0, 0, 1);
        run(`CYT_OP_MOV_DD, 8'h21, 3, 3, 0, 0, 1);
        run(8'h75, 8'h22, 3, 3, 0, 0, 1);
        run(8'h90, 8'h12, 3, 3, 0, 0, 1);
    endtask

    task automatic t_memx();
        logic [7:0] ops [6];
        ops = '{`CYT_OP_CODE_DP, `CYT_OP_CODE_PC, 8'hE2, 8'hF3, `CYT_OP_XRD_DP, `CYT_OP_XWR_DP};
        foreach (ops[k]) run(ops[k], 8'h00, 1, 3, 0, 0, 1);
    endtask

    task automatic t_stack();
        run(`CYT_OP_PUSH, 8'h81, 2, 2, 0, 0, 1);
        run(`CYT_OP_POP, 8'h82, 2, 2, 0, 0, 1);
        run(8'hCD, 8'h00, 1, 1, 0, 0, 1);
        run(8'hC5, 8'h30, 2, 2, 0, 0, 1);
        run(8'hC7, 8'h00, 1, 2, 0, 0, 1);
        run(8'hD7, 8'h00, 1, 2, 0, 0, 1);
    endtask

    task automatic t_bits();
        run(8'hC3, 8'h00, 1, 1, 0, 0, 1);
        run(8'hD3, 8'h00, 1, 1, 0, 0, 1);
        run(8'hB3, 8'h00, 1, 1, 0, 0, 1);
        run(8'hC2, 8'h08, 2, 2, 0, 0, 1);
        run(8'hD2, 8'h09, 2, 2, 0, 0, 1);
        run(8'hB2, 8'h0A, 2, 2, 0, 0, 1);
        run(8'h82, 8'h0B, 2, 2, 0, 0, 1);
    endtask

    task automatic t_branch();
        run(`CYT_OP_JC, 8'h10, 2, 2, 0, 0, 1);
        run(`CYT_OP_JC, 8'h10, 2, 2, 1, 0, 1);
        // Outside the decoded set, timed as a plain single cycle
        run(8'h02, 8'h00, 1, 1, 0, 0, 0);
    endtask

    // Operand locations for bank, pointer and direct forms
    task automatic t_oper();
        bank_sel = 2'h2;
        run(8'h2B, 8'h00, 1, 1, 0, 0, 1);
        check("oper_bank", oper, 32'h213);
        bank_sel = 2'h1;
        run(8'h27, 8'h00, 1, 2, 0, 0, 1);
        check("oper_ind", oper, 32'h209);
        run(8'h25, 8'h80, 2, 2, 0, 0, 1);
        check("oper_sfr", oper, 32'h380);
        run(8'h25, 8'h7F, 2, 2, 0, 0, 1);
        check("oper_ram", oper, 32'h27F);
    endtask

    // A missing byte stretches the instruction but not its count
    task automatic t_stall();
        run(8'h75, 8'h23, 3, 3, 0, 1, 1);
        run(`CYT_OP_JC, 8'h10, 2, 2, 1, 1, 1);
    endtask

    // Reset in the middle of a multiply
    task automatic t_reset();
        code_byte = `CYT_OP_MUL;
        code_valid = 1'b1;
        @(negedge clk);
        code_valid = 1'b0;
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check("fetch_req_rst", fetch_req, 0);
        check("instr_done_rst", instr_done, 0);
        rst_n = 1'b1;
        @(negedge clk);
        @(negedge clk);
        check("fetch_req_boot", fetch_req, 1);
        run(`CYT_OP_DIV, 8'h00, 1, 8, 0, 0, 1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_arith();
        t_muldiv();
        t_logic();
        t_acc();
        t_move();
        t_memx();
        t_stack();
        t_bits();
        t_branch();
        t_oper();
        t_stall();
        t_reset();
        stop_test();
    end
endmodule // cyt_sequencer_tb_top
`default_nettype wire
